/* core/acr_core.sv */
// Summary of operation
// - Master clock is 384 fs when ratio select high, 256 fs when low.
// - Divide master clock to a 64 fs modulator tick; words at fs.
// - Master mode makes all serial clocks from the master clock.
// - Reset clears decimation state and the output data buffer.
// - In reset serial data, flag, word and channel clock outputs low, power-down high, bit clock at polarity select level.
// - Reset may arrive asynchronously to the master clock.
// - Devices sharing clock and reset start sampling on the same cycle.
// - Slave mode stays static until channel clock falls then rises.
// - Word clock input mode waits for word high with channel_select_clock high, low, high.
// - Master calibration starts right after reset, lasting 8192 channel periods.
// - Slave calibration count starts after the first fall-then-rise.
// - Held reset means power-down with conversions stopped.
// - Leaving power-down starts in reset state, then calibration.
// - Two-bit level flag per sample, MSB first, with the channel clock.
// - Flag 00 under, 01 within under, 10 within over, 11 over.
// - Level flag follows the current sample, no peak hold.
// - Polarity high: data changes on falling bit clock edge, else rising.
// - Slave select high means slave mode, low means master.
// - Slave: bit and channel clocks are inputs; word clock input in one mode.

// ************************************************
// Sample buffer
// ************************************************
module acr_fifo #(
	parameter int WIDTH = 36,
	parameter int DEPTH = 4
) (
	// Clock and reset
	input  wire logic             ref_clk,
	input  wire logic             rst_n,
	// Fill side
	input  wire logic [WIDTH-1:0] inData,
	input  wire logic             inValid,
	output logic                  inReady,
	// Drain side
	output logic [WIDTH-1:0]      outData,
	output logic                  outValid,
	input  wire logic             outReady
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0]               wr;
		logic [AW-1:0]               rd;
		logic [AW:0]                 count;
	} acr_fifo_state_t;

	acr_fifo_state_t st;
	acr_fifo_state_t next_st;
	logic            push;
	logic            pop;

	assign inReady  = st.count != (AW+1)'(DEPTH);
	assign outValid = st.count != '0;
	assign outData  = st.mem[st.rd];
	assign push     = inValid & inReady;
	assign pop      = outReady & outValid;

	always_comb begin
		next_st = st;
		if (push) begin
			next_st.mem[st.wr] = inData;
			next_st.wr = (st.wr == AW'(DEPTH - 1)) ? '0 : st.wr + 1'b1;
		end
		if (pop) begin
			next_st.rd = (st.rd == AW'(DEPTH - 1)) ? '0 : st.rd + 1'b1;
		end
		next_st.count = st.count + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

endmodule // acr_fifo

// ************************************************
// Converter control
// ************************************************
module acr_core import acr_pkg::*; #(
	parameter int CAL_LEN = CAL_PERIODS
) (
	// Clock and reset
	input  wire logic  ref_clk,
	input  wire logic  rst_n,
	// Pin straps
	input  acr_mode_t  mode,
	// Slave clock inputs
	input  wire logic  bitClkIn,
	input  wire logic  channelSelectClockIn,
	input  wire logic  wordFrameClkIn,
	// Sample stream from decimator
	input  acr_frame_t sampleData,
	input  wire logic  sampleValid,
	output logic       sampleReady,
	// Serial port
	output logic       serialData,
	output logic       tagOut,
	output logic       bitClkOut,
	output logic       bitClkOe,
	output logic       channelSelectClockOut,
	output logic       channelSelectClockOe,
	output logic       wordFrameClkOut,
	output logic       wordFrameClkOe,
	// Status
	output logic       modTick,
	output logic       sampleTick,
	output logic       calBusy,
	output logic       sampling,
	output logic       powerDown
);
	localparam logic [13:0] CAL_LAST = 14'(CAL_LEN - 1);

	acr_state_t st;
	acr_state_t next_st;
	acr_frame_t fifoData;
	logic       fifoValid;
	logic       fifoPop;
	logic       lRise;
	logic       lFall;
	logic       master;
	logic       pol;
	logic       wclkInMode;
	logic       rjPulse;
	logic       active;
	logic       divLast;
	logic [2:0] half;
	logic [4:0] modeStart;

	acr_fifo #(
		.WIDTH ($bits(acr_frame_t)),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.ref_clk  (ref_clk),
		.rst_n    (rst_n),
		.inData   (sampleData),
		.inValid  (sampleValid),
		.inReady  (sampleReady),
		.outData  (fifoData),
		.outValid (fifoValid),
		.outReady (fifoPop)
	);

	assign master     = ~mode.slaveSel;
	assign pol        = mode.bitClkPolaritySel;
	assign wclkInMode = mode.slaveSel & mode.justifySel
		& ~mode.msbDelaySel;
	assign rjPulse    = master & mode.justifySel & ~mode.msbDelaySel;
	assign active     = (st.phase == PH_CAL) || (st.phase == PH_RUN);
	assign divLast    = st.divCnt >= (mode.ratio384 ? DIV_LAST_384
		: DIV_LAST_256);
	assign half       = mode.ratio384 ? HALF_384 : HALF_256;
	assign modeStart  = wclkInMode ? NO_START
		: mode.justifySel ? (mode.msbDelaySel ? RJ_START : RJ1_START)
		: (mode.msbDelaySel ? LJ_START : I2S_START);

	always_comb begin
		logic       bNow;
		logic       tx;
		logic [4:0] fb;
		logic [4:0] off;
		logic       inWin;
		bNow    = 1'b0;
		tx      = 1'b0;
		fb      = 5'h00;
		off     = 5'h00;
		inWin   = 1'b0;
		next_st = st;
		fifoPop = 1'b0;
		lRise   = 1'b0;
		lFall   = 1'b0;
		next_st.rsync      = {st.rsync[0], 1'b1};
		next_st.modTick    = 1'b0;
		next_st.sampleTick = 1'b0;
		next_st.load       = 1'b0;
		// Nothing moves before the release is synchronised
		if (st.rsync[1]) begin
			next_st.divCnt  = divLast ? 3'h0 : st.divCnt + 3'h1;
			next_st.modTick = divLast;
			bNow = master ? (next_st.divCnt < half) : bitClkIn;
			tx = pol ? (st.bclk & ~bNow) : (~st.bclk & bNow);
			next_st.bclk = bNow;
			if (tx && active) begin
				if (master) begin
					next_st.bitIdx = st.bitIdx + 6'h01;
					next_st.channel_select_clock   = ~next_st.bitIdx[5];
				end else begin
					next_st.bitIdx[5]   = ~channelSelectClockIn;
					next_st.bitIdx[4:0] = st.restart ? 5'h00
						: st.bitIdx[4:0] + 5'h01;
					next_st.restart     = 1'b0;
				end
				fb = next_st.bitIdx[4:0];
				if (fb == 5'h00) begin
					next_st.load   = 1'b1;
					next_st.dStart = modeStart;
					// Left field opens a new sample pair
					if (!next_st.bitIdx[5]) begin
						fifoPop            = fifoValid;
						next_st.sampleTick = 1'b1;
						if (fifoValid) begin
							next_st.frame = fifoData;
						end
						next_st.word = next_st.frame.left.data;
						next_st.tag  = {next_st.frame.left.overFs,
							next_st.frame.left.overFs
							^ next_st.frame.left.nearFs};
					end else begin
						next_st.word = next_st.frame.right.data;
						next_st.tag  = {next_st.frame.right.overFs,
							next_st.frame.right.overFs
							^ next_st.frame.right.nearFs};
					end
				end
				// MSB goes out in the bit after word clock seen high
				if (wclkInMode && wordFrameClkIn
					&& next_st.dStart == NO_START) begin
					next_st.dStart = fb + 5'h01;
				end
				off   = fb - next_st.dStart;
				inWin = (fb >= next_st.dStart) && !off[4];
				next_st.sdo    = inWin & next_st.word[~off[3:0]];
				next_st.tagOut = (fb == 5'h00) ? next_st.tag[1]
					: (fb == TAG_LSB_BIT) ? next_st.tag[0]
					: 1'b0;
				next_st.wclk   = wclkInMode ? 1'b0
					: rjPulse ? (fb == RJ_START) : inWin;
			end
			if (!master) begin
				next_st.channel_select_clock = channelSelectClockIn;
			end
			lRise = ~st.channel_select_clock & next_st.channel_select_clock;
			lFall = st.channel_select_clock & ~next_st.channel_select_clock;
			// Set wins over the clear done on a bit tick
			if (!master && (lRise || lFall)) begin
				next_st.restart = 1'b1;
			end
			if (wordFrameClkIn && st.wseq != WSEQ_DONE
				&& channelSelectClockIn == ~st.wseq[0]) begin
				next_st.wseq = st.wseq + 2'h1;
			end
			case (st.phase)
				PH_WAIT_FALL: begin
					if (master) begin
						next_st.phase = PH_CAL;
					end else if (lFall) begin
						next_st.phase = PH_WAIT_RISE;
					end
				end
				PH_WAIT_RISE: begin
					if (lRise) begin
						next_st.phase = wclkInMode ? PH_WAIT_WORD
							: PH_CAL;
					end
				end
				PH_WAIT_WORD: begin
					if (next_st.wseq == WSEQ_DONE) begin
						next_st.phase = PH_CAL;
					end
				end
				PH_CAL: begin
					if (lRise) begin
						if (st.calCnt == CAL_LAST) begin
							next_st.phase = PH_RUN;
						end else begin
							next_st.calCnt = st.calCnt + 14'h0001;
						end
					end
				end
				PH_RUN: begin
					next_st.phase = PH_RUN;
				end
				default: begin
					next_st.phase = PH_WAIT_FALL;
				end
			endcase
		end
	end

	// Async assert, constant reset value only
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= STATE_RESET;
		end else begin
			st <= next_st;
		end
	end

	assign serialData            = st.sdo;
	assign tagOut                = st.tagOut;
	assign bitClkOut             = st.rsync[1] ? st.bclk : pol;
	assign bitClkOe              = master;
	assign channelSelectClockOut = master & st.channel_select_clock;
	assign channelSelectClockOe  = master;
	assign wordFrameClkOut       = st.wclk;
	assign wordFrameClkOe        = ~wclkInMode;
	assign modTick               = st.modTick;
	assign sampleTick            = st.sampleTick;
	assign calBusy               = st.phase == PH_CAL;
	assign sampling              = active;
	assign powerDown             = ~st.rsync[1];

	// ************************************************
	// Checks
	// ************************************************
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	property p_div256;
		(st.modTick && !mode.ratio384) |=> !st.modTick [*3] ##1 st.modTick;
	endproperty
	a_div256: assert property (p_div256)
		else $error("256 mode tick spacing wrong");

	property p_div384;
		(st.modTick && mode.ratio384) |=> !st.modTick [*5] ##1 st.modTick;
	endproperty
	a_div384: assert property (p_div384)
		else $error("384 mode tick spacing wrong");

	property p_frame;
		(st.sampleTick && master && !mode.ratio384) |-> ##256 st.sampleTick;
	endproperty
	a_frame: assert property (p_frame)
		else $error("master sample period not 64 modulator ticks");

	property p_resetOut;
		!st.rsync[1] |-> (!serialData && !tagOut && !wordFrameClkOut
			&& !channelSelectClockOut && bitClkOut == pol);
	endproperty
	a_resetOut: assert property (p_resetOut)
		else $error("outputs not at reset levels");

	property p_slaveHold;
		(!master && !active) |-> (!wordFrameClkOut && !serialData && !tagOut);
	endproperty
	a_slaveHold: assert property (p_slaveHold)
		else $error("slave outputs moved before start");

	property p_calLen;
		$rose(st.phase == PH_RUN) |-> $past(st.calCnt) == CAL_LAST;
	endproperty
	a_calLen: assert property (p_calLen)
		else $error("calibration length wrong");

	property p_calStart;
		(!master && $rose(calBusy) && !wclkInMode) |-> $past(lRise);
	endproperty
	a_calStart: assert property (p_calStart)
		else $error("slave calibration began without channel clock rise");

	property p_pwr;
		powerDown |-> !sampling && !sampleTick;
	endproperty
	a_pwr: assert property (p_pwr)
		else $error("converting while powered down");

	property p_tag;
		(st.load && !st.bitIdx[5]) |-> tagOut == st.frame.left.overFs;
	endproperty
	a_tag: assert property (p_tag)
		else $error("flag MSB does not match current left sample");

endmodule // acr_core

/* core/acr_pkg.sv */
package acr_pkg;

	// ************************************************
	// Clock division and frame layout
	// ************************************************
	localparam logic [2:0] DIV_LAST_256 = 3'h3;
	localparam logic [2:0] DIV_LAST_384 = 3'h5;
	localparam logic [2:0] HALF_256     = 3'h2;
	localparam logic [2:0] HALF_384     = 3'h3;
	localparam logic [5:0] FRAME_LAST   = 6'h3F;
	localparam logic [4:0] LJ_START     = 5'h00;
	localparam logic [4:0] I2S_START    = 5'h01;
	localparam logic [4:0] RJ_START     = 5'h10;
	localparam logic [4:0] RJ1_START    = 5'h11;
	localparam logic [4:0] NO_START     = 5'h1F;
	localparam logic [4:0] TAG_LSB_BIT  = 5'h01;
	localparam int         CAL_PERIODS  = 8192;
	localparam int         FIFO_DEPTH   = 4;
	localparam logic [1:0] WSEQ_DONE    = 2'h3;

	// ************************************************
	// Types
	// ************************************************
	typedef enum logic [2:0] {
		PH_WAIT_FALL = 3'b000,
		PH_WAIT_RISE = 3'b001,
		PH_WAIT_WORD = 3'b010,
		PH_CAL       = 3'b011,
		PH_RUN       = 3'b100
	} acr_phase_t;

	typedef struct packed {
		logic        ratio384;
		logic        bitClkPolaritySel;
		logic        slaveSel;
		logic        justifySel;
		logic        msbDelaySel;
	} acr_mode_t;

	typedef struct packed {
		logic [15:0] data;
		logic        overFs;
		logic        nearFs;
	} acr_sample_t;

	typedef struct packed {
		acr_sample_t left;
		acr_sample_t right;
	} acr_frame_t;

	typedef struct packed {
		logic [1:0]  rsync;
		acr_phase_t  phase;
		logic [1:0]  wseq;
		logic [2:0]  divCnt;
		logic        bclk;
		logic        channel_select_clock;
		logic [5:0]  bitIdx;
		logic        restart;
		logic [13:0] calCnt;
		logic [4:0]  dStart;
		logic [15:0] word;
		logic [1:0]  tag;
		acr_frame_t  frame;
		logic        sdo;
		logic        tagOut;
		logic        wclk;
		logic        modTick;
		logic        sampleTick;
		logic        load;
	} acr_state_t;

	localparam acr_state_t STATE_RESET = '{
		rsync: 2'h0, phase: PH_WAIT_FALL, wseq: 2'h0, divCnt: 3'h0,
		bclk: 1'b0, channel_select_clock: 1'b0, bitIdx: FRAME_LAST, restart: 1'b0,
		calCnt: 14'h0000, dStart: NO_START, word: 16'h0000, tag: 2'h0,
		frame: '0, sdo: 1'b0, tagOut: 1'b0, wclk: 1'b0,
		modTick: 1'b0, sampleTick: 1'b0, load: 1'b0};

endpackage

/* verification/acr_rx_model.sv */
// ************************************************
// Receiver side: supplies slave bit and channel clocks
// ************************************************
module acr_rx_model (
	// Clock and reset
	input  wire logic ref_clk,
	input  wire logic rst_n,
	// Control
	input  wire logic enable,
	// Slave clocks
	output logic      bitClk,
	output logic      chanClk
);
	timeunit 1ns;
	timeprecision 100ps;

	logic [7:0] cnt;

	// Divided from the master clock, never a free source
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= 8'h00;
		end else if (enable) begin
			cnt <= cnt + 8'h01;
		end
	end

	// Still while disabled, holding their levels; after reset bit clock low, channel clock high
	assign bitClk  = cnt[1];
	assign chanClk = ~cnt[7];

endmodule // acr_rx_model

/* verification/tb_adc_clock_reset_cal_overrange.sv */
module tb_adc_clock_reset_cal_overrange import acr_pkg::*; ();
	timeunit 1ns;
	timeprecision 100ps;

	logic       ref_clk = 1'h0;
	logic       rst_n;
	acr_mode_t  mode;
	acr_frame_t sampleData;
	logic       sampleValid;
	logic       sampleReady;
	logic       pEn;
	logic       wIn;
	logic       bitClkIn;
	logic       chanIn;
	logic       serialData;
	logic       tagOut;
	logic       bitClkOut;
	logic       bitClkOe;
	logic       channelSelectClockOut;
	logic       channelSelectClockOe;
	logic       wordFrameClkOut;
	logic       wordFrameClkOe;
	logic       modTick;
	logic       sampleTick;
	logic       calBusy;
	logic       sampling;
	logic       powerDown;
	logic [3:0] watch;
	logic [8:0] rstView;
	int         n_errors = 0;
	int         n_tests = 0;
	int         cycles = 0;

	// Arbitrary sample word; its first two bits are checked on the line
	localparam logic [15:0] SAMPLE_WORD = 16'hA5C3;

	always #12.5 ref_clk = ~ref_clk;

	// Short calibration keeps the run brief
	acr_core #(.CAL_LEN(4)) i_dut (
		.ref_clk              (ref_clk),
		.rst_n                (rst_n),
		.mode                 (mode),
		.bitClkIn             (bitClkIn),
		.channelSelectClockIn (chanIn),
		.wordFrameClkIn       (wIn),
		.sampleData           (sampleData),
		.sampleValid          (sampleValid),
		.sampleReady          (sampleReady),
		.serialData           (serialData),
		.tagOut               (tagOut),
		.bitClkOut            (bitClkOut),
		.bitClkOe             (bitClkOe),
		.channelSelectClockOut(channelSelectClockOut),
		.channelSelectClockOe (channelSelectClockOe),
		.wordFrameClkOut      (wordFrameClkOut),
		.wordFrameClkOe       (wordFrameClkOe),
		.modTick              (modTick),
		.sampleTick           (sampleTick),
		.calBusy              (calBusy),
		.sampling             (sampling),
		.powerDown            (powerDown)
	);

	acr_rx_model i_rx (
		.ref_clk(ref_clk),
		.rst_n  (rst_n),
		.enable (pEn),
		.bitClk (bitClkIn),
		.chanClk(chanIn)
	);

	// Index: 0 modTick, 1 sampleTick, 2 calBusy, 3 sampling
	assign watch   = {sampling, calBusy, sampleTick, modTick};
	assign rstView = {serialData, tagOut, channelSelectClockOut,
		wordFrameClkOut, modTick, sampleTick, calBusy, sampling, powerDown};

	// ************************************************
	// Checking and reporting
	// ************************************************
	task automatic print_verdict;
		$display("checks %0d errors %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [9:0] got, input logic [9:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_n(input int got, input int exp);
		n_tests++;
		if (got != exp) begin
			n_errors++;
			$display("ERROR at %0t: count %0d expected %0d", $time, got, exp);
		end
	endtask

	task automatic end_test(input string s);
		$display("test %s done", s);
	endtask

	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 20000) begin
			n_errors++;
			$display("ERROR at %0t: run too long", $time);
			print_verdict();
		end
	end

	// ************************************************
	// Access tasks
	// ************************************************
	task automatic wait_bit(input int idx, input logic lvl, input int lim);
		int n;
		n = 0;
		while (watch[idx] !== lvl && n < lim) begin
			@(negedge ref_clk);
			n++;
		end
		chk(watch[idx], lvl);
	endtask

	task automatic period(input int idx, input int exp);
		int n;
		wait_bit(idx, 1'h1, 1000);
		n = 0;
		do begin
			@(negedge ref_clk);
			n++;
		end while (watch[idx] !== 1'h1 && n < exp + 8);
		chk_n(n, exp);
	endtask

	// Leaves valid up so pushes can run back to back
	task automatic push(input logic ov, input logic nr);
		acr_frame_t f;
		f = '0;
		f.left.data = SAMPLE_WORD;
		f.left.overFs = ov;
		f.left.nearFs = nr;
		sampleData = f;
		sampleValid = 1'h1;
		@(negedge ref_clk);
	endtask

	task automatic rst_run(input logic r384, input logic pol,
		input logic sl, input logic js, input logic md);
		@(negedge ref_clk);
		#5 rst_n = 1'h0;
		#1 chk(rstView, 9'h001);
		@(negedge ref_clk);
		mode = '{ratio384: r384, bitClkPolaritySel: pol, slaveSel: sl,
			justifySel: js, msbDelaySel: md};
		pEn = 1'h0;
		repeat (4) @(negedge ref_clk);
		chk({rstView, bitClkOut}, {9'h001, pol});
		rst_n = 1'h1;
		@(negedge ref_clk);
		chk(sampleReady, 1'h1);
	endtask

	// ************************************************
	// Tests
	// ************************************************
	initial begin
		rst_n = 1'h0;
		sampleValid = 1'h0;
		sampleData = '0;
		pEn = 1'h0;
		wIn = 1'h0;
		mode = '0;
		rst_run(1'h0, 1'h1, 1'h1, 1'h0, 1'h1);
		push(1'h0, 1'h0);
		push(1'h0, 1'h1);
		push(1'h1, 1'h1);
		push(1'h1, 1'h0);
		sampleValid = 1'h0;
		repeat (300) @(negedge ref_clk);
		chk({calBusy, sampling, serialData, tagOut, wordFrameClkOut,
			bitClkOe, channelSelectClockOe, sampleReady}, 8'h00);
		pEn = 1'h1;
		repeat (200) @(negedge ref_clk);
		chk(calBusy, 1'h0);
		wait_bit(2, 1'h1, 100);
		repeat (700) @(negedge ref_clk);
		chk(calBusy, 1'h1);
		wait_bit(2, 1'h0, 500);
		chk({sampling, sampleReady}, 2'h3);
		end_test("slave start");

		rst_run(1'h0, 1'h0, 1'h0, 1'h0, 1'h1);
		wait_bit(2, 1'h1, 2);
		chk(powerDown, 1'h0);
		period(0, 4);
		period(1, 256);
		chk({channelSelectClockOut, channelSelectClockOe, bitClkOe}, 3'h7);
		chk({wordFrameClkOe, wordFrameClkOut}, 2'h3);
		chk(bitClkOut, 1'h1);
		for (int c = 0; c < 4; c++) begin
			push(c[1], c[1] ^ c[0]);
			sampleValid = 1'h0;
			repeat (3) period(1, 256);
			chk(tagOut, c[1]);
			chk(serialData, SAMPLE_WORD[15]);
			repeat (4) @(negedge ref_clk);
			chk(tagOut, c[0]);
			chk(serialData, SAMPLE_WORD[14]);
		end
		end_test("master 256");

		rst_run(1'h1, 1'h1, 1'h0, 1'h0, 1'h1);
		period(0, 6);
		period(1, 384);
		chk(bitClkOut, 1'h0);
		end_test("master 384");

		// Word clock input: start waits for the word clock sequence
		rst_run(1'h0, 1'h1, 1'h1, 1'h1, 1'h0);
		pEn = 1'h1;
		repeat (300) @(negedge ref_clk);
		chk({calBusy, wordFrameClkOe, wordFrameClkOut}, 3'h0);
		wIn = 1'h1;
		wait_bit(2, 1'h1, 600);
		end_test("slave word clock input");
		print_verdict();
	end

endmodule // tb_adc_clock_reset_cal_overrange
